// ---- rtl/cpst_core.sv ----
// CPU status word, program counter, stack and vector sequencer.
`timescale 1ns/10ps
// Functional notes
// (RULE1) Interrupts other than reset and break are blocked while I is 0.
// (RULE2) I set by enable, cleared by disable and on interrupt service.
// (RULE3) H set on carry out of bit 3 or no borrow from bit 4.
// (RULE4) Only clear-overflow clears H explicitly, together with V.
// (RULE5) Break sets B to tell it from the table call sharing its vector.
// (RULE6) Direct addressing uses 00-0FF when G is 0, upper page when 1.
// (RULE7) G is set only by set-page and cleared only by clear-page.
// (RULE8) V sets on signed overflow, cleared only by clear-overflow; bit test here also loads V from bit 6, so it can clear V.
// (RULE9) Bit test copies memory bit 6 to V and bit 7 to N.
// (RULE10) N follows bit 7 of each transfer or arithmetic result.
// (RULE11) Program counter wraps from FFFF to 0000.
// (RULE12) After reset the start address is fetched from FFFE and FFFF.
// (RULE13) Table-call vectors are two bytes each, entry 15 at FFC0 upward.
// (RULE14) Page call is the two-byte call into the FF00 page.
// (RULE15) Interrupt vectors are two bytes each from FFE0, reset at FFFE.
// (RULE16) Unused vector locations are ordinary program memory.
// (RULE17) Control registers decode in data addresses 0C0 to 0FF.
// (RULE18) Unimplemented control addresses read undefined, writes ignored.
// (RULE19) Software writes write-only registers with whole bytes only.
// (RULE20) Calls and interrupts push PC; return restores PC, INTERRUPT_RETURN_INSTR also flags.
// (RULE21) SP decrements after each save and increments before each restore.
// (RULE22) Page register acts after set-page; clear-page always selects page 0.
// (RULE23) Stack lives in 100-1FF; SP has no reset value, software loads it.
// (RULE24) Interrupt pushes PC high, PC low, status; return pops in reverse.
module cpst_core
  import cpst_pkg::*;
#(
  parameter int NUM_IRQ = 15
) (
  // Clock, reset and enable.
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  // Avalon-MM slave.
  input  wire logic [5:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output logic      [31:0]        o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // Interrupt sources and acknowledge.
  input  wire logic [NUM_IRQ-1:0] i_irq,
  output logic                    o_irq_ack,
  output logic      [3:0]         o_irq_id,
  // Architectural state view.
  output logic      [15:0]        o_pc,
  output logic      [7:0]         o_psw,
  output logic                    o_busy
);
  cpst_mem_if mem ();

  cpst_mem u_mem (
    .i_clk (i_clk),
    .i_ce  (i_ce),
    .bus   (mem)
  );

  cpst_state_t           state_reg;
  logic [15:0]           pc_reg, vec_reg, target_reg, maddr_reg, result_reg;
  logic [7:0]            psw_reg, sp_reg, tmp_reg;
  logic [2:0]            rpr_reg, page_reg;
  logic [1:0]            class_reg;
  logic                  push_psw_reg, need_vec_reg, rd_done_reg, ack_reg;
  logic [3:0]            ack_id_reg;
  logic [NUM_IRQ-1:0]    irq_s1_reg, irq_s2_reg, irq_s3_reg, irq_lvl_reg;
  logic [31:0]           rd_val;
  logic [7:0]            op, opa, opb, sub_dif;
  logic [8:0]            add_sum;
  logic [4:0]            add_nib;
  logic                  idle, irq_take, wr_ok, wr_go, cmd_take, add_ovf, sub_ovf;
  logic [3:0]            irq_id;

  // Data address of a direct operand: page only when G is set.
  function automatic logic [15:0] dir_addr(input logic g, input logic [2:0] pg,
                                           input logic [7:0] off);
    return g ? {5'h00, pg, off} : {8'h00, off};
  endfunction

  // Stack byte address for a stack pointer value.
  function automatic logic [15:0] stk_addr(input logic [7:0] p);
    return {STACK_PAGE, p};
  endfunction

  // Class of a 10-bit data address.
  function automatic logic [1:0] data_class(input logic [9:0] a);
    if (a >= CTL_LO && a <= CTL_HI) begin
      return CLS_CTL;
    end
    return (a[9:8] == 2'h1) ? CLS_STACK : CLS_RAM;
  endfunction

  // Highest-numbered pending source wins.
  function automatic logic [3:0] pick_irq(input logic [NUM_IRQ-1:0] v);
    logic [3:0] id;
    id = 4'h0;
    for (int k = 0; k < NUM_IRQ; k++) begin
      if (v[k]) begin
        id = 4'(k);
      end
    end
    return id;
  endfunction

  // Command fields and ALU results.
  assign op      = i_avs_writedata[7:0];
  assign opa     = i_avs_writedata[15:8];
  assign opb     = i_avs_writedata[23:16];
  assign add_sum = {1'b0, opa} + {1'b0, opb};
  assign add_nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
  assign sub_dif = opa - opb;
  assign add_ovf = (opa[7] == opb[7]) && (add_sum[7] != opa[7]);
  assign sub_ovf = (opa[7] != opb[7]) && (sub_dif[7] != opa[7]);

  // Bus acceptance; register writes wait while the sequencer is busy.
  assign idle     = (state_reg == ST_IDLE);
  assign irq_take = i_ce && idle && psw_reg[PSW_I] && (|irq_lvl_reg); // RULE1
  assign irq_id   = pick_irq(irq_lvl_reg);
  assign wr_ok    = i_ce && idle && !irq_take;
  assign wr_go    = i_avs_write && wr_ok && (i_avs_byteenable == 4'hF);
  assign cmd_take = wr_go && (i_avs_address == REG_CMD);
  assign o_avs_waitrequest = (i_avs_write && !wr_ok) || (i_avs_read && !rd_done_reg);
  assign o_busy   = !idle;
  assign o_pc     = pc_reg;
  assign o_psw    = psw_reg;
  assign o_irq_ack = ack_reg;
  assign o_irq_id  = ack_id_reg;

  // Three-stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_s1_reg  <= '0;
      irq_s2_reg  <= '0;
      irq_s3_reg  <= '0;
      irq_lvl_reg <= '0;
    end else if (i_ce) begin
      irq_s1_reg  <= i_irq;
      irq_s2_reg  <= irq_s1_reg;
      irq_s3_reg  <= irq_s2_reg;
      irq_lvl_reg <= (irq_s2_reg & irq_s3_reg) | (irq_lvl_reg & (irq_s2_reg | irq_s3_reg));
    end
  end

  // Memory port: the sequencer owns it while busy, the bus window otherwise.
  always_comb begin
    mem.addr  = maddr_reg;
    mem.we    = wr_go && (i_avs_address == REG_MDATA);
    mem.wdata = i_avs_writedata[7:0];
    unique case (state_reg)
      ST_PUSH_H: begin
        mem.addr  = stk_addr(sp_reg);
        mem.we    = 1'b1;
        mem.wdata = pc_reg[15:8];
      end
      ST_PUSH_L: begin
        mem.addr  = stk_addr(sp_reg);
        mem.we    = 1'b1;
        mem.wdata = pc_reg[7:0];
      end
      ST_PUSH_P: begin
        mem.addr  = stk_addr(sp_reg);
        mem.we    = 1'b1;
        mem.wdata = tmp_reg;
      end
      ST_VEC_L:  mem.addr = vec_reg;
      ST_VEC_H:  mem.addr = vec_reg + 16'h0001;
      ST_POP_P, ST_POP_L, ST_POP_H: mem.addr = stk_addr(sp_reg + 8'h01); // RULE21
      default:   ;
    endcase
  end

  // Sequencer: service entry, calls, vector fetch and returns.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg    <= ST_VEC_L;
      vec_reg      <= VEC_RESET; // RULE12
      target_reg   <= PC_RST;
      tmp_reg      <= 8'h00;
      push_psw_reg <= 1'b0;
      need_vec_reg <= 1'b1;
    end else if (i_ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (irq_take) begin
            vec_reg      <= VEC_IRQ_BASE + {11'h000, irq_id, 1'b0}; // RULE15
            tmp_reg      <= psw_reg;
            push_psw_reg <= 1'b1; // RULE24
            need_vec_reg <= 1'b1;
            state_reg    <= ST_PUSH_H; // RULE20
          end else if (cmd_take) begin
            push_psw_reg <= 1'b0;
            need_vec_reg <= 1'b1;
            if (op == OP_BRK) begin
              vec_reg      <= VEC_TCALL0;
              tmp_reg      <= psw_reg | 8'h10;
              push_psw_reg <= 1'b1;
              state_reg    <= ST_PUSH_H;
            end else if (op == OP_TABLE_CALL_INSTR) begin
              vec_reg   <= VEC_TCALL0 - {11'h000, opa[3:0], 1'b0}; // RULE13
              state_reg <= ST_PUSH_H;
            end else if (op == OP_PAGE_CALL_INSTR) begin
              target_reg   <= {PAGE_CALL_INSTR_PAGE, opa}; // RULE14
              need_vec_reg <= 1'b0;
              state_reg    <= ST_PUSH_H;
            end else if (op == OP_CALL) begin
              target_reg   <= {opb, opa};
              need_vec_reg <= 1'b0;
              state_reg    <= ST_PUSH_H;
            end else if (op == OP_RET) begin
              state_reg <= ST_POP_L; // RULE20
            end else if (op == OP_INTERRUPT_RETURN_INSTR) begin
              state_reg <= ST_POP_P; // RULE20
            end else if (op == OP_RSTVEC) begin
              vec_reg   <= VEC_RESET; // RULE12
              state_reg <= ST_VEC_L;
            end
          end
        end
        ST_PUSH_H: state_reg <= ST_PUSH_L;
        ST_PUSH_L: begin
          if (push_psw_reg) begin
            state_reg <= ST_PUSH_P;
          end else if (need_vec_reg) begin
            state_reg <= ST_VEC_L;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PUSH_P: state_reg <= ST_VEC_L;
        ST_VEC_L: begin
          tmp_reg   <= mem.rdata;
          state_reg <= ST_VEC_H;
        end
        ST_VEC_H:  state_reg <= ST_IDLE;
        ST_POP_P:  state_reg <= ST_POP_L; // RULE24
        ST_POP_L: begin
          tmp_reg   <= mem.rdata;
          state_reg <= ST_POP_H;
        end
        ST_POP_H:  state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Program counter: bus load, increment, jump and fetched addresses.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_reg <= PC_RST;
    end else if (i_ce) begin
      if (wr_go && i_avs_address == REG_PC) begin
        pc_reg <= i_avs_writedata[15:0];
      end else if (cmd_take && op == OP_INCPC) begin
        pc_reg <= pc_reg + 16'h0001; // RULE11
      end else if (state_reg == ST_PUSH_L && !push_psw_reg && !need_vec_reg) begin
        pc_reg <= target_reg;
      end else if (state_reg == ST_VEC_H || state_reg == ST_POP_H) begin
        pc_reg <= {mem.rdata, tmp_reg};
      end
    end
  end

  // Stack pointer has no reset value and must be loaded by software.
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (wr_go && i_avs_address == REG_SP) begin
        sp_reg <= i_avs_writedata[7:0]; // RULE23
      end else if (state_reg == ST_PUSH_H || state_reg == ST_PUSH_L ||
                   state_reg == ST_PUSH_P) begin
        sp_reg <= sp_reg - 8'h01; // RULE21
      end else if (state_reg == ST_POP_P || state_reg == ST_POP_L ||
                   state_reg == ST_POP_H) begin
        sp_reg <= sp_reg + 8'h01; // RULE21
      end
    end
  end

  // Status word flags.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psw_reg <= PSW_RST;
    end else if (i_ce) begin
      if (irq_take) begin
        psw_reg[PSW_I] <= 1'b0; // RULE2
      end else if (state_reg == ST_POP_P) begin
        psw_reg <= mem.rdata; // RULE20
      end else if (cmd_take) begin
        unique case (op)
          OP_EI:   psw_reg[PSW_I] <= 1'b1; // RULE2
          OP_DI:   psw_reg[PSW_I] <= 1'b0; // RULE2
          OP_CLEAR_OVERFLOW_INSTR: begin
            psw_reg[PSW_V] <= 1'b0; // RULE8
            psw_reg[PSW_H] <= 1'b0; // RULE4
          end
          OP_SET_PAGE_INSTR: psw_reg[PSW_G] <= 1'b1; // RULE7
          OP_CLEAR_PAGE_INSTR: psw_reg[PSW_G] <= 1'b0; // RULE7
          OP_BRK:  psw_reg[PSW_B] <= 1'b1; // RULE5
          OP_ADD: begin
            psw_reg[PSW_N] <= add_sum[7]; // RULE10
            psw_reg[PSW_Z] <= (add_sum[7:0] == 8'h00);
            psw_reg[PSW_C] <= add_sum[8];
            psw_reg[PSW_H] <= add_nib[4]; // RULE3
            psw_reg[PSW_V] <= psw_reg[PSW_V] | add_ovf; // RULE8
          end
          OP_SUB: begin
            psw_reg[PSW_N] <= sub_dif[7]; // RULE10
            psw_reg[PSW_Z] <= (sub_dif == 8'h00);
            psw_reg[PSW_C] <= (opa >= opb);
            psw_reg[PSW_H] <= (opa[3:0] >= opb[3:0]); // RULE3
            psw_reg[PSW_V] <= psw_reg[PSW_V] | sub_ovf; // RULE8
          end
          OP_BIT: begin
            psw_reg[PSW_V] <= opa[6]; // RULE9
            psw_reg[PSW_N] <= opa[7]; // RULE9
            psw_reg[PSW_Z] <= ((opa & opb) == 8'h00);
          end
          OP_LOAD: begin
            psw_reg[PSW_N] <= opa[7]; // RULE10
            psw_reg[PSW_Z] <= (opa == 8'h00);
          end
          default: ;
        endcase
      end
    end
  end

  // Page register, active page, memory window address and results.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rpr_reg    <= RPR_RST;
      page_reg   <= RPR_RST;
      maddr_reg  <= 16'h0000;
      result_reg <= 16'h0000;
      class_reg  <= CLS_RAM;
    end else if (i_ce && wr_go) begin
      if (i_avs_address == REG_RPR) begin
        rpr_reg <= i_avs_writedata[2:0];
      end
      if (i_avs_address == REG_MADDR) begin
        maddr_reg <= i_avs_writedata[15:0];
      end
      if (cmd_take && op == OP_SET_PAGE_INSTR) begin
        page_reg <= rpr_reg; // RULE22
      end
      if (cmd_take && op == OP_DIRADR) begin
        result_reg <= dir_addr(psw_reg[PSW_G], page_reg, opa); // RULE6 RULE22
      end
      if (cmd_take && op == OP_ADD) begin
        result_reg <= {8'h00, add_sum[7:0]};
      end
      if (cmd_take && op == OP_SUB) begin
        result_reg <= {8'h00, sub_dif};
      end
      if (cmd_take && op == OP_LOAD) begin
        result_reg <= {8'h00, opa};
      end
      if (cmd_take && op == OP_DECODE) begin
        result_reg <= {6'h00, opb[1:0], opa};
        class_reg  <= data_class({opb[1:0], opa}); // RULE17 RULE18
      end
    end
  end

  // Read mux; the window returns zero for unbacked addresses.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (i_avs_address)
      REG_STATUS: rd_val = {20'h00000, page_reg, !idle, psw_reg};
      REG_PC:     rd_val = {16'h0000, pc_reg};
      REG_SP:     rd_val = {24'h000000, sp_reg};
      REG_RPR:    rd_val = {29'h00000000, rpr_reg};
      REG_RESULT: rd_val = {14'h0000, class_reg, result_reg};
      REG_MADDR:  rd_val = {16'h0000, maddr_reg};
      REG_MDATA:  rd_val = {23'h000000, mem.hit, mem.rdata}; // RULE18
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  // Reads answer one cycle after they are seen; window reads wait for idle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_done_reg    <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce) begin
      rd_done_reg <= i_avs_read && !rd_done_reg && (idle || i_avs_address != REG_MDATA);
      if (i_avs_read && !rd_done_reg) begin
        o_avs_readdata <= rd_val;
      end
    end
  end

  // Acknowledge pulse to the serviced source.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg    <= 1'b0;
      ack_id_reg <= 4'h0;
    end else if (i_ce) begin
      ack_reg <= irq_take;
      if (irq_take) begin
        ack_id_reg <= irq_id;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  sequence push_pc_s;
    state_reg == ST_PUSH_H ##1 state_reg == ST_PUSH_L;
  endsequence
  sequence pop_all_s;
    state_reg == ST_POP_P ##1 state_reg == ST_POP_L ##1 state_reg == ST_POP_H
      ##1 state_reg == ST_IDLE;
  endsequence

  irq_gate_a: assert property (o_irq_ack |-> $past(psw_reg[PSW_I]) && $past(idle)) // RULE1
    else $error("interrupt accepted while disabled");
  ien_clear_a: assert property (o_irq_ack |-> !psw_reg[PSW_I] ##1 state_reg == ST_PUSH_L) // RULE2
    else $error("I not cleared on service");
  half_carry_a: assert property (cmd_take && op == OP_ADD |=> // RULE3
      psw_reg[PSW_H] == $past(add_nib[4]))
    else $error("half carry wrong after add");
  brk_flag_a: assert property (cmd_take && op == OP_BRK |=> psw_reg[PSW_B] ##0 push_pc_s) // RULE5
    else $error("break did not set B and push");
  ovf_cause_a: assert property ($rose(psw_reg[PSW_V]) |-> // RULE8
      $past(cmd_take && (op == OP_ADD || op == OP_SUB || op == OP_BIT)) ||
      $past(state_reg == ST_POP_P))
    else $error("V set without a cause");
  pc_wrap_a: assert property (cmd_take && op == OP_INCPC && pc_reg == 16'hFFFF |=> // RULE11
      pc_reg == 16'h0000)
    else $error("PC did not wrap");
  page_zero_a: assert property (cmd_take && op == OP_DIRADR && !psw_reg[PSW_G] |=> // RULE22
      result_reg[15:8] == 8'h00)
    else $error("direct address left page zero");
  call_stack_a: assert property (cmd_take && op == OP_CALL |=> push_pc_s ##1 // RULE21
      state_reg == ST_IDLE && sp_reg == $past(sp_reg, 2) - 8'h02)
    else $error("call did not push two bytes");
  interrupt_return_instr_pop_a: assert property (cmd_take && op == OP_INTERRUPT_RETURN_INSTR |=> pop_all_s) // RULE24
    else $error("interrupt return sequence broken");
  irq_vec_a: assert property (o_irq_ack |-> // RULE15
      vec_reg == VEC_IRQ_BASE + {11'h000, o_irq_id, 1'b0})
    else $error("interrupt vector address wrong");
endmodule

// ---- common/cpst_pkg.sv ----
// Shared constants for the CPU architectural state unit.
package cpst_pkg;
  // Avalon word offsets (byte addresses).
  localparam logic [5:0] REG_CMD    = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_PC     = 6'h08;
  localparam logic [5:0] REG_SP     = 6'h0C;
  localparam logic [5:0] REG_RPR    = 6'h10;
  localparam logic [5:0] REG_RESULT = 6'h14;
  localparam logic [5:0] REG_MADDR  = 6'h18;
  localparam logic [5:0] REG_MDATA  = 6'h1C;
  // Status word bit positions.
  localparam int PSW_C = 0;
  localparam int PSW_Z = 1;
  localparam int PSW_I = 2;
  localparam int PSW_H = 3;
  localparam int PSW_B = 4;
  localparam int PSW_G = 5;
  localparam int PSW_V = 6;
  localparam int PSW_N = 7;
  // Values after reset.
  localparam logic [7:0]  PSW_RST = 8'h00;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [2:0]  RPR_RST = 3'h0;
  // Program space vectors and pages.
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ_BASE = 16'hFFE0;
  localparam logic [15:0] VEC_TCALL0   = 16'hFFDE;
  localparam logic [7:0]  PAGE_CALL_INSTR_PAGE   = 8'hFF;
  localparam logic [7:0]  TOP_PAGE     = 8'hFF;
  localparam logic [7:0]  STACK_PAGE   = 8'h01;
  // Data space control-register window.
  localparam logic [9:0]  CTL_LO = 10'h0C0;
  localparam logic [9:0]  CTL_HI = 10'h0FF;
  // Data address classes.
  localparam logic [1:0]  CLS_RAM   = 2'h0;
  localparam logic [1:0]  CLS_CTL   = 2'h1;
  localparam logic [1:0]  CLS_STACK = 2'h2;
  // Command codes written to the command register.
  localparam logic [7:0] OP_NOP    = 8'h00;
  localparam logic [7:0] OP_EI     = 8'h01;
  localparam logic [7:0] OP_DI     = 8'h02;
  localparam logic [7:0] OP_CLEAR_OVERFLOW_INSTR   = 8'h03;
  localparam logic [7:0] OP_SET_PAGE_INSTR   = 8'h04;
  localparam logic [7:0] OP_CLEAR_PAGE_INSTR   = 8'h05;
  localparam logic [7:0] OP_BRK    = 8'h06;
  localparam logic [7:0] OP_TABLE_CALL_INSTR  = 8'h07;
  localparam logic [7:0] OP_PAGE_CALL_INSTR  = 8'h08;
  localparam logic [7:0] OP_CALL   = 8'h09;
  localparam logic [7:0] OP_RET    = 8'h0A;
  localparam logic [7:0] OP_INTERRUPT_RETURN_INSTR   = 8'h0B;
  localparam logic [7:0] OP_ADD    = 8'h0C;
  localparam logic [7:0] OP_SUB    = 8'h0D;
  localparam logic [7:0] OP_BIT    = 8'h0E;
  localparam logic [7:0] OP_LOAD   = 8'h0F;
  localparam logic [7:0] OP_INCPC  = 8'h10;
  localparam logic [7:0] OP_DIRADR = 8'h11;
  localparam logic [7:0] OP_DECODE = 8'h12;
  localparam logic [7:0] OP_RSTVEC = 8'h13;
  // Sequencer states, Gray coded along the push and pop paths.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_PUSH_H = 4'h1,
    ST_PUSH_L = 4'h3,
    ST_PUSH_P = 4'h2,
    ST_VEC_L  = 4'h6,
    ST_VEC_H  = 4'h7,
    ST_POP_P  = 4'h8,
    ST_POP_L  = 4'h9,
    ST_POP_H  = 4'hB
  } cpst_state_t;
endpackage

// ---- common/cpst_mem_if.sv ----
// Byte port between the sequencer and the stack and top-page memories.
`timescale 1ns/10ps
interface cpst_mem_if;
  logic [15:0] addr;
  logic        we;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hit;
  modport core (output addr, output we, output wdata, input rdata, input hit);
  modport mem  (input addr, input we, input wdata, output rdata, output hit);
endinterface

// ---- rtl/cpst_mem.sv ----
// Stack page and top program page byte memories.
`timescale 1ns/10ps
module cpst_mem
  import cpst_pkg::*;
(
  // Clock and enable.
  input wire logic i_clk,
  input wire logic i_ce,
  // Byte port.
  cpst_mem_if.mem  bus
);
  logic [7:0] stack_mem [256];
  logic [7:0] top_mem   [256];

  // Writes land in the stack or top page that the address selects, other pages are dropped; vectors are plain bytes.
  always_ff @(posedge i_clk) begin
    if (i_ce && bus.we) begin
      if (bus.addr[15:8] == STACK_PAGE) begin
        stack_mem[bus.addr[7:0]] <= bus.wdata;
      end else if (bus.addr[15:8] == TOP_PAGE) begin
        top_mem[bus.addr[7:0]] <= bus.wdata; // RULE16
      end
    end
  end

  // Reads are immediate; unbacked addresses return zero.
  always_comb begin
    bus.hit   = 1'b0;
    bus.rdata = 8'h00;
    if (bus.addr[15:8] == STACK_PAGE) begin
      bus.hit   = 1'b1;
      bus.rdata = stack_mem[bus.addr[7:0]];
    end else if (bus.addr[15:8] == TOP_PAGE) begin
      bus.hit   = 1'b1;
      bus.rdata = top_mem[bus.addr[7:0]];
    end
  end
endmodule

// ---- test/test_cpst_core.sv ----
// Self-checking bench for the CPU architectural state unit.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_cpst_core
  import cpst_pkg::*;
;
  logic        i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, wq, ack, busy;
  logic [14:0] irq = 0;
  logic [5:0]  adr = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [15:0] pc;
  logic [7:0]  cpu_status_word;
  logic [3:0]  id;
  int          n_errors = 0, checks = 0, n_ack = 0, k;
  // Device under test with every lane enabled and the clock running.
  cpst_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_irq(irq), .o_irq_ack(ack),
    .o_irq_id(id), .o_pc(pc), .o_psw(cpu_status_word), .o_busy(busy));
  // Clock at 100 MHz and a count of accepted interrupts.
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (ack === 1'b1) n_ack++;
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low at a rising edge.
  // Whole-word writes only, so write-only state never sees partial updates.
  task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= r; wr <= !r; adr <= a; wd <= d;
    do begin
      @(posedge i_clk); n++;
    end while (wq !== 1'b0 && n < 60);
    q = rdat;
    rd <= 0; wr <= 0;
    if (n >= 60) begin n_errors++; wrap_up(); end
    @(posedge i_clk);
  endtask
  // Command issue; waits for the sequencer to finish so reads see final state.
  task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    bus(0, REG_CMD, {8'h00, b, a, op});
    while (busy !== 1'b0 && n < 60) begin @(posedge i_clk); n++; end
    if (n >= 60) begin n_errors++; wrap_up(); end
  endtask
  task automatic mem(input logic [15:0] a, input logic [7:0] d);
    bus(0, REG_MADDR, {16'h0, a}); bus(0, REG_MDATA, {24'h0, d});
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1; @(posedge i_clk);
    mem(16'hFFFE, 8'h00); mem(16'hFFFF, 8'h40); mem(16'hFFFC, 8'h00); mem(16'hFFFD, 8'h50);
    cmd(OP_RSTVEC, 0, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'h4000)
    bus(1, REG_STATUS, 0); `CHK(q[7:0], 8'h00)
    cmd(OP_ADD, 8'h7F, 8'h01); bus(1, REG_STATUS, 0); `CHK(q[7:0], 8'hC8)
    cmd(OP_CLEAR_OVERFLOW_INSTR, 0, 0); bus(1, REG_STATUS, 0); `CHK(q[7:0], 8'h80)
    cmd(OP_BIT, 8'h40, 8'h01); bus(1, REG_STATUS, 0); `CHK(q[7:6], 2'b01)
    cmd(OP_CLEAR_OVERFLOW_INSTR, 0, 0);
    bus(0, REG_RPR, 1); cmd(OP_SET_PAGE_INSTR, 0, 0); cmd(OP_DIRADR, 8'h25, 0);
    bus(1, REG_RESULT, 0); `CHK(q[15:0], 16'h0125)
    bus(1, REG_STATUS, 0); `CHK(q[5], 1'b1)
    cmd(OP_CLEAR_PAGE_INSTR, 0, 0); cmd(OP_DIRADR, 8'h25, 0);
    bus(1, REG_RESULT, 0); `CHK(q[15:0], 16'h0025)
    cmd(OP_DECODE, 8'hC5, 0); bus(1, REG_RESULT, 0); `CHK(q[17:16], 2'h1)
    bus(0, REG_PC, 32'hFFFF); cmd(OP_INCPC, 0, 0);
    bus(1, REG_PC, 0); `CHK(q[15:0], 16'h0000)
    bus(0, REG_SP, 32'hFF); bus(0, REG_PC, 32'h1234); cmd(OP_CALL, 8'h78, 8'h56);
    bus(1, REG_PC, 0); `CHK(q[15:0], 16'h5678)
    bus(1, REG_SP, 0); `CHK(q[7:0], 8'hFD)
    bus(0, REG_MADDR, 32'h01FF); bus(1, REG_MDATA, 0); `CHK(q[7:0], 8'h12)
    cmd(OP_RET, 0, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'h1234)
    bus(1, REG_SP, 0); `CHK(q[7:0], 8'hFF)
    mem(16'hFFC0, 8'h00); mem(16'hFFC1, 8'h60); mem(16'hFFDE, 8'h00); mem(16'hFFDF, 8'h70);
    cmd(OP_TABLE_CALL_INSTR, 8'h0F, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'h6000)
    cmd(OP_PAGE_CALL_INSTR, 8'h35, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'hFF35)
    cmd(OP_BRK, 0, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'h7000)
    bus(1, REG_STATUS, 0); `CHK(q[4], 1'b1)
    bus(0, REG_SP, 32'hFF); bus(0, REG_PC, 32'h1234);
    irq[14] <= 1; repeat (20) @(posedge i_clk); `CHK(n_ack, 0)
    cmd(OP_EI, 0, 0);
    for (k = 0; k < 40 && n_ack == 0; k++) @(posedge i_clk);
    `CHK(id, 4'hE)
    irq <= 0; cmd(OP_NOP, 0, 0);
    bus(1, REG_PC, 0); `CHK(q[15:0], 16'h5000)
    bus(1, REG_STATUS, 0); `CHK(q[2], 1'b0)
    bus(1, REG_SP, 0); `CHK(q[7:0], 8'hFC)
    cmd(OP_INTERRUPT_RETURN_INSTR, 0, 0); bus(1, REG_PC, 0); `CHK(q[15:0], 16'h1234)
    bus(1, REG_STATUS, 0); `CHK(q[2], 1'b1)
    cmd(OP_DI, 0, 0); bus(1, REG_STATUS, 0); `CHK(q[2], 1'b0)
    `CHK(n_ack, 1)
    wrap_up();
  end
endmodule
